// ===== dv/flash_status_reg_two_props.sv
// assertion checker for the second status register
`timescale 1ns/100ps
module flash_status_reg_two_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_data,
  input wire logic write_enable_latch,
  input wire logic op_busy,
  input wire logic protect_mode_lo,
  input wire logic protect_mode_lock,
  input wire logic region_bp_hit,
  input wire logic otp_prog_valid,
  input wire logic [1:0] otp_prog_reg,
  input wire logic [6:0] otp_prog_byte,
  input wire logic io_drive_req,
  input wire logic [7:0] status_two_q,
  input wire logic cmd_refused,
  input wire logic sr_write_refused_q,
  input wire logic array_write_ok,
  input wire logic otp_prog_ok,
  input wire logic [3:0] otp_locked,
  input wire logic wp_function_active,
  input wire logic device_reset_evt,
  input wire logic data_line_two_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ============================================
  // decoded events; a write racing a reset is not judged
  wire suspend_flag = cmd_valid && cmd_opcode == 8'h75 && op_busy;
  wire wr = cmd_valid && cmd_opcode == 8'h31 && write_enable_latch &&
    !device_reset_evt;
  wire qop = cmd_opcode inside {8'h6b, 8'heb, 8'he7, 8'h32, 8'h77, 8'h94};
  a_suspend_set: assert property (suspend_flag |=> status_two_q[7])
    else $error("suspend flag not set");
  a_suspend_clear: assert property (
    (cmd_valid && cmd_opcode == 8'h7a) || (device_reset_evt && !suspend_flag)
    |=> !status_two_q[7]) else $error("suspend flag not cleared");
  a_map_invert: assert property (
    array_write_ok == (status_two_q[6] == region_bp_hit))
    else $error("protection map wrong");
  a_reserved_zero: assert property (!status_two_q[2])
    else $error("reserved bit set");
  a_quad_gate: assert property (
    cmd_refused == (cmd_valid && qop && !status_two_q[1]))
    else $error("quad gating wrong");
  a_pin_roles: assert property (
    wp_function_active == !status_two_q[1]) else $error("pin role wrong");
  a_drive_follow: assert property (!$past(reset) |->
    data_line_two_oe == $past(io_drive_req && status_two_q[1]))
    else $error("drive enable wrong");
  a_write_take: assert property (
    wr && !status_two_q[0] && !protect_mode_lo && !otp_prog_valid |=>
    status_two_q == ($past(status_two_q) & 8'hb8 | $past(cmd_data) & 8'h43))
    else $error("write fields wrong");
  a_write_lockdown: assert property (wr && status_two_q[0] |=>
    sr_write_refused_q ##0 $stable(status_two_q & 8'h43))
    else $error("locked write taken");
  a_reset_mode: assert property (device_reset_evt |=>
    status_two_q[0] == $past(status_two_q[0] && protect_mode_lo &&
    protect_mode_lock)) else $error("mode after reset wrong");
  a_lock_set: assert property (
    otp_prog_valid && otp_prog_byte == 7'h7f |=>
    otp_locked == ($past(otp_locked) | 4'h1 << $past(otp_prog_reg)))
    else $error("lock not set");
  a_lock_view: assert property (
    status_two_q[5:3] == otp_locked[3:1] && otp_locked[0])
    else $error("lock view wrong");
  a_lock_gate: assert property (
    otp_prog_ok == (otp_prog_valid && !otp_locked[otp_prog_reg]))
    else $error("locked register programmed");
  c_suspend: cover property (suspend_flag);
  c_lockdown: cover property (wr && status_two_q[0]);
  c_lock: cover property (otp_prog_valid && otp_prog_byte == 7'h7f);
endmodule
bind flash_status_reg_two flash_status_reg_two_props chk (
  .clk(clk),
  .reset(reset),
  .cmd_valid(cmd_valid),
  .cmd_opcode(cmd_opcode),
  .cmd_data(cmd_data),
  .write_enable_latch(write_enable_latch),
  .op_busy(op_busy),
  .protect_mode_lo(protect_mode_lo),
  .protect_mode_lock(protect_mode_lock),
  .region_bp_hit(region_bp_hit),
  .otp_prog_valid(otp_prog_valid),
  .otp_prog_reg(otp_prog_reg),
  .otp_prog_byte(otp_prog_byte),
  .io_drive_req(io_drive_req),
  .status_two_q(status_two_q),
  .cmd_refused(cmd_refused),
  .sr_write_refused_q(sr_write_refused_q),
  .array_write_ok(array_write_ok),
  .otp_prog_ok(otp_prog_ok),
  .otp_locked(otp_locked),
  .wp_function_active(wp_function_active),
  .device_reset_evt(device_reset_evt),
  .data_line_two_oe(data_line_two_oe)
);

// ===== dv/flash_status_reg_two_test.sv
// self-checking bench for the second status register
`timescale 1ns/100ps
module flash_status_reg_two_test;
  logic clk = 1'b0, reset = 1'b1, write_enable_latch = 1'b1;
  logic op_busy = 1'b0, jedec_reset_evt = 1'b0, protect_mode_lo = 1'b0;
  logic protect_mode_lock = 1'b0, hold_reset_select = 1'b0;
  logic region_bp_hit = 1'b0, hw_reset_n_i = 1'b1, otp_prog_valid = 1'b0;
  logic io_drive_req = 1'b0;
  logic [1:0] otp_prog_reg = 2'h0, io_drive_data = 2'h2;
  logic [6:0] otp_prog_byte = 7'h00;
  logic cmd_valid, wp_pin, hold_pin, cmd_refused, sr_write_refused_q;
  logic array_write_ok, otp_prog_ok, quad_io_enable, wp_function_active;
  logic hold_function_active, device_reset_evt, data_line_two_o;
  logic data_line_two_oe, data_line_three_o, data_line_three_oe;
  logic [7:0] cmd_opcode, cmd_data, status_two_q;
  logic [3:0] otp_locked;
  logic [1:0] io_sample_q;
  int num_errors = 0, checked = 0;
  // pin level: device when enabled, else host
  wire data_line_two_i = data_line_two_oe ? data_line_two_o : wp_pin;
  wire data_line_three_i = data_line_three_oe ? data_line_three_o : hold_pin;
  always #4 clk = ~clk;
  host_model host (
    .clk(clk),
    .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode),
    .cmd_data(cmd_data),
    .wp_pin(wp_pin),
    .hold_pin(hold_pin)
  );
  flash_status_reg_two DUT (
    .clk(clk),
    .reset(reset),
    .cmd_valid(cmd_valid),
    .cmd_opcode(cmd_opcode),
    .cmd_data(cmd_data),
    .write_enable_latch(write_enable_latch),
    .op_busy(op_busy),
    .jedec_reset_evt(jedec_reset_evt),
    .protect_mode_lo(protect_mode_lo),
    .protect_mode_lock(protect_mode_lock),
    .hold_reset_select(hold_reset_select),
    .region_bp_hit(region_bp_hit),
    .otp_prog_valid(otp_prog_valid),
    .otp_prog_reg(otp_prog_reg),
    .otp_prog_byte(otp_prog_byte),
    .data_line_two_i(data_line_two_i),
    .data_line_three_i(data_line_three_i),
    .hw_reset_n_i(hw_reset_n_i),
    .io_drive_data(io_drive_data),
    .io_drive_req(io_drive_req),
    .status_two_q(status_two_q),
    .cmd_refused(cmd_refused),
    .sr_write_refused_q(sr_write_refused_q),
    .array_write_ok(array_write_ok),
    .otp_prog_ok(otp_prog_ok),
    .otp_locked(otp_locked),
    .quad_io_enable(quad_io_enable),
    .wp_function_active(wp_function_active),
    .hold_function_active(hold_function_active),
    .device_reset_evt(device_reset_evt),
    .io_sample_q(io_sample_q),
    .data_line_two_o(data_line_two_o),
    .data_line_two_oe(data_line_two_oe),
    .data_line_three_o(data_line_three_o),
    .data_line_three_oe(data_line_three_oe)
  );
  // ============================================
  // shared helpers
  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic cmd(input logic [7:0] o, input logic [7:0] d);
    host.issue(o, d);
    host.idle();
  endtask
  task automatic wr(input logic [7:0] d, input logic [7:0] e, input logic r);
    cmd(8'h31, d);
    chk(status_two_q === e && sr_write_refused_q === r, "write");
  endtask
  task automatic prog(input logic [1:0] r, input logic [6:0] b, input logic e);
    @(negedge clk);
    {otp_prog_valid, otp_prog_reg, otp_prog_byte} = {1'b1, r, b};
    #1 chk(otp_prog_ok === e, "otp gate");
    @(negedge clk);
    otp_prog_valid = 1'b0;
  endtask
  task automatic conclude();
    $display("checked %0d, num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ============================================
  // scenarios
  task automatic t_reset();
    chk(status_two_q === 8'h00 && otp_locked === 4'h1, "reset");
    hold_reset_select = 1'b1;
    #1 chk(hold_function_active === 1'b0, "hold role");
    @(negedge clk);
    hold_reset_select = 1'b0;
    #1 chk(hold_function_active === 1'b1, "hold kept");
  endtask
  task automatic t_quad_gate();
    logic [7:0] ops [6] = '{8'h6b, 8'heb, 8'he7, 8'h32, 8'h77, 8'h94};
    foreach (ops[i]) begin
      host.issue(ops[i], 8'h00);
      #1 chk(cmd_refused === ~status_two_q[1], "quad gate");
      host.idle();
    end
  endtask
  task automatic t_invert();
    region_bp_hit = 1'b1;
    wr(8'hfe, 8'h42, 1'b0);
    chk(array_write_ok === 1'b1, "invert");
    wr(8'h00, 8'h00, 1'b0);
    chk(array_write_ok === 1'b0, "plain map");
  endtask
  task automatic t_suspend();
    op_busy = 1'b1;
    cmd(8'h75, 8'h00);
    chk(status_two_q === 8'h80, "suspend");
    wr(8'h00, 8'h80, 1'b0);
    cmd(8'h7a, 8'h00);
    chk(status_two_q[7] === 1'b0, "resume");
    cmd(8'h75, 8'h00);
    jedec_reset_evt = 1'b1;
    #1 chk(device_reset_evt === 1'b1, "reset event");
    @(negedge clk);
    jedec_reset_evt = 1'b0;
    chk(status_two_q[7] === 1'b0, "jedec reset");
    cmd(8'h75, 8'h00);
    cmd(8'h66, 8'h00);
    cmd(8'h99, 8'h00);
    chk(status_two_q[7] === 1'b0, "soft reset");
    cmd(8'h75, 8'h00);
    hw_reset_n_i = 1'b0;
    repeat (6) @(negedge clk);
    hw_reset_n_i = 1'b1;
    chk(status_two_q[7] === 1'b0, "pin reset");
  endtask
  task automatic t_otp();
    prog(2'h1, 7'h7e, 1'b1);
    prog(2'h1, 7'h7f, 1'b1);
    prog(2'h3, 7'h7f, 1'b1);
    chk(status_two_q[5:3] === 3'h5, "lock map");
    prog(2'h1, 7'h00, 1'b0);
    prog(2'h0, 7'h00, 1'b0);
    wr(8'h02, 8'h2a, 1'b0);
  endtask
  task automatic t_pins();
    io_drive_data = 2'h1;
    io_drive_req = 1'b1;
    repeat (2) @(negedge clk);
    chk(data_line_two_oe === 1'b1 && data_line_three_oe === 1'b1 &&
      data_line_two_o === 1'b1 && data_line_three_o === 1'b0 &&
      quad_io_enable === 1'b1, "drive");
    io_drive_req = 1'b0;
    host.pins(1'b0, 1'b1);
    repeat (6) @(negedge clk);
    chk(io_sample_q === 2'h2 &&
      wp_function_active === 1'b0, "quad io");
  endtask
  task automatic t_protect();
    wr(8'h00, 8'h28, 1'b0);
    protect_mode_lo = 1'b1;
    repeat (6) @(negedge clk);
    wr(8'h40, 8'h28, 1'b1);
    host.pins(1'b1, 1'b1);
    repeat (6) @(negedge clk);
    wr(8'h01, 8'h29, 1'b0);
    wr(8'h00, 8'h29, 1'b1);
    cmd(8'h66, 8'h00);
    cmd(8'h99, 8'h00);
    chk(status_two_q === 8'h28, "lockdown release");
    protect_mode_lo = 1'b0;
    wr(8'h01, 8'h29, 1'b0);
    wr(8'h40, 8'h29, 1'b1);
    protect_mode_lo = 1'b1;
    protect_mode_lock = 1'b1;
    cmd(8'h66, 8'h00);
    cmd(8'h99, 8'h00);
    wr(8'h00, 8'h29, 1'b1);
    @(negedge clk);
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    chk(status_two_q === 8'h00, "second reset");
  endtask
  // ============================================
  // watchdog cuts a hang short
  initial begin
    #100000;
    num_errors++;
    conclude();
  end
  initial begin
    repeat (2) @(negedge clk);
    reset = 1'b0;
    t_reset();
    t_quad_gate();
    t_invert();
    t_suspend();
    t_otp();
    t_quad_gate();
    t_pins();
    t_protect();
    conclude();
  end
endmodule

// ===== dv/host_model.sv
// host side: issues decoded commands and drives the wp and hold pins
`timescale 1ns/100ps
module host_model (
  input wire logic clk,
  output logic cmd_valid,
  output logic [7:0] cmd_opcode,
  output logic [7:0] cmd_data,
  output logic wp_pin,
  output logic hold_pin
);
  // ============================================
  // idle: no command, pins pulled high
  initial begin
    cmd_valid = 1'b0;
    cmd_opcode = 8'h00;
    cmd_data = 8'h00;
    wp_pin = 1'b1;
    hold_pin = 1'b1;
  end
  // raise one command; held over the next rising edge
  task automatic issue(input logic [7:0] o, input logic [7:0] d);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_opcode = o;
    cmd_data = d;
  endtask
  // released bus shows the inverse so stale values never match
  task automatic idle();
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_opcode = ~cmd_opcode;
    cmd_data = ~cmd_data;
  endtask
  // host drives the wp and hold pins: data in quad mode, control levels otherwise
  task automatic pins(input logic w, input logic h);
    @(negedge clk);
    wp_pin = w;
    hold_pin = h;
  endtask
endmodule

// ===== rtl/flash_status_reg_two.sv
// second status register with suspend, invert, otp lock and quad logic
`timescale 1ns/100ps
module flash_status_reg_two (
  input wire logic clk,
  input wire logic reset,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_data,
  input wire logic write_enable_latch,
  input wire logic op_busy,
  input wire logic jedec_reset_evt,
  input wire logic protect_mode_lo,
  input wire logic protect_mode_lock,
  input wire logic hold_reset_select,
  input wire logic region_bp_hit,
  input wire logic otp_prog_valid,
  input wire logic [1:0] otp_prog_reg,
  input wire logic [6:0] otp_prog_byte,
  input wire logic data_line_two_i,
  input wire logic data_line_three_i,
  input wire logic hw_reset_n_i,
  input wire logic [1:0] io_drive_data,
  input wire logic io_drive_req,
  output logic [7:0] status_two_q,
  output logic cmd_refused,
  output logic sr_write_refused_q,
  output logic array_write_ok,
  output logic otp_prog_ok,
  output logic [3:0] otp_locked,
  output logic quad_io_enable,
  output logic wp_function_active,
  output logic hold_function_active,
  output logic device_reset_evt,
  output logic [1:0] io_sample_q,
  output logic data_line_two_o,
  output logic data_line_two_oe,
  output logic data_line_three_o,
  output logic data_line_three_oe
);

  // =======================================================
  // pin synchronisers
  pin_sync_if pins ();
  logic wp_n_s;
  logic hold_n_s;
  logic hw_reset_n_s;

  // the wp and hold pins double as data lines two and three
  assign pins.raw = {hw_reset_n_i, data_line_three_i, data_line_two_i};
  assign wp_n_s = pins.clean[0];
  assign hold_n_s = pins.clean[1];
  assign hw_reset_n_s = pins.clean[2];

  pin_sync u_pin_sync (
    .clk(clk),
    .reset(reset),
    .pins(pins)
  );

  // =======================================================
  // register state
  logic suspend_flag_q;
  logic suspend_flag_d;
  logic protect_invert_q;
  logic protect_invert_d;
  logic [2:0] otp_lock_bits_q;
  logic [2:0] otp_lock_bits_d;
  logic quad_io_enable_q;
  logic quad_io_enable_d;
  logic protect_mode_hi_q;
  logic protect_mode_hi_d;
  logic sr_write_refused_d;
  logic hw_reset_seen_q;
  logic hw_reset_seen_d;
  status_two_pkg::swr_state_t swr_q;
  status_two_pkg::swr_state_t swr_d;

  // =======================================================
  // command decode
  logic is_suspend;
  logic is_resume;
  logic is_write;
  logic sw_reset_evt;
  logic hw_reset_evt;
  logic quad_cmd;
  logic sr_locked;
  logic wp_low;

  // quad-only opcodes are refused while quad enable is clear
  always_comb begin
    unique case (cmd_opcode)
      status_two_pkg::OP_QUAD_OUT_READ,
      status_two_pkg::OP_XIP_READ,
      status_two_pkg::OP_XIP_READ_DW: quad_cmd = 1'b1; // [RULE_13]
      status_two_pkg::OP_QUAD_PAGE_PROG,
      status_two_pkg::OP_BURST_WRAP,
      status_two_pkg::OP_QUAD_ID_READ: quad_cmd = 1'b1; // [RULE_14]
      default: quad_cmd = 1'b0;
    endcase
  end

  assign cmd_refused = cmd_valid & quad_cmd & ~quad_io_enable_q;
  assign is_suspend = cmd_valid && cmd_opcode == status_two_pkg::OP_SUSPEND;
  assign is_resume = cmd_valid && cmd_opcode == status_two_pkg::OP_RESUME;
  assign is_write = cmd_valid &&
    cmd_opcode == status_two_pkg::OP_WRITE_STATUS_TWO;

  // wp pin counts only in its control role
  assign wp_low = ~quad_io_enable_q & ~wp_n_s; // [RULE_11] [RULE_12]

  // write protection from the two mode bits and the wp pin
  always_comb begin
    unique case ({protect_mode_hi_q, protect_mode_lo})
      2'b00: sr_locked = 1'b0;
      2'b01: sr_locked = wp_low; // [RULE_16]
      2'b10: sr_locked = 1'b1;
      2'b11: sr_locked = 1'b1; // [RULE_17]
    endcase
  end

  // =======================================================
  // software reset pair: enable then reset as the next command
  always_comb begin
    swr_d = swr_q;
    sw_reset_evt = 1'b0;
    if (cmd_valid) begin
      unique case (swr_q)
        status_two_pkg::SWR_IDLE: begin
          if (cmd_opcode == status_two_pkg::OP_RESET_ENABLE) begin
            swr_d = status_two_pkg::SWR_ARMED;
          end
        end
        status_two_pkg::SWR_ARMED: begin
          sw_reset_evt = cmd_opcode == status_two_pkg::OP_RESET;
          if (cmd_opcode != status_two_pkg::OP_RESET_ENABLE) begin
            swr_d = status_two_pkg::SWR_IDLE;
          end
        end
      endcase
    end
  end

  // pairing state; a reset drops any half-seen enable
  always_ff @(posedge clk) begin
    if (reset) begin
      swr_q <= status_two_pkg::SWR_IDLE;
    end else begin
      swr_q <= swr_d;
    end
  end

  // =======================================================
  // hardware reset on the reset pin or the hold/reset pin, edge of the settled level
  // the hold pin's reset role only exists while quad enable is clear
  always_comb begin
    hw_reset_seen_d = ~hw_reset_n_s |
      (~quad_io_enable_q & hold_reset_select & ~hold_n_s); // [RULE_18]
  end

  // settled level history; starts idle so no false edge after reset
  always_ff @(posedge clk) begin
    if (reset) begin
      hw_reset_seen_q <= 1'b0;
    end else begin
      hw_reset_seen_q <= hw_reset_seen_d;
    end
  end

  assign hw_reset_evt = hw_reset_seen_d & ~hw_reset_seen_q;
  assign device_reset_evt = hw_reset_evt | jedec_reset_evt | sw_reset_evt;

  // =======================================================
  // suspend flag; clears first so a same-cycle suspend still lands
  always_comb begin
    suspend_flag_d = suspend_flag_q;
    if (is_resume || device_reset_evt) begin
      suspend_flag_d = 1'b0; // [RULE_02]
    end
    if (is_suspend && op_busy) begin
      suspend_flag_d = 1'b1; // [RULE_01]
    end
  end

  // suspend flag register
  always_ff @(posedge clk) begin
    if (reset) begin
      suspend_flag_q <= 1'b0;
    end else begin
      suspend_flag_q <= suspend_flag_d;
    end
  end

  // =======================================================
  // register next values
  always_comb begin
    protect_invert_d = protect_invert_q;
    otp_lock_bits_d = otp_lock_bits_q;
    quad_io_enable_d = quad_io_enable_q;
    protect_mode_hi_d = protect_mode_hi_q;
    sr_write_refused_d = 1'b0;
    // device reset drops reset lockdown but keeps the otp form
    if (device_reset_evt) begin
      protect_mode_hi_d = protect_mode_hi_q & protect_mode_lo &
        protect_mode_lock; // [RULE_17]
    end
    // only bits 6, 1 and 0 take written data
    if (is_write && write_enable_latch && !device_reset_evt) begin
      if (sr_locked) begin
        sr_write_refused_d = 1'b1; // [RULE_16]
      end else begin
        protect_invert_d = cmd_data[status_two_pkg::INVERT_BIT]; // [RULE_03]
        quad_io_enable_d = cmd_data[status_two_pkg::QUAD_BIT]; // [RULE_10]
        protect_mode_hi_d = cmd_data[status_two_pkg::MODE_HI_BIT]; // [RULE_15]
      end
    end
    // lock bits are sticky; writing the last byte locks the register
    if (otp_prog_ok && otp_prog_byte == status_two_pkg::SEC_LAST_BYTE) begin
      unique case (otp_prog_reg)
        2'h0: otp_lock_bits_d = otp_lock_bits_q; // refused before this
        2'h1: otp_lock_bits_d[0] = 1'b1; // [RULE_07] [RULE_06]
        2'h2: otp_lock_bits_d[1] = 1'b1;
        2'h3: otp_lock_bits_d[2] = 1'b1;
      endcase
    end
  end

  // configuration, lock and refusal registers
  always_ff @(posedge clk) begin
    if (reset) begin
      protect_invert_q <= 1'b0;
      otp_lock_bits_q <= status_two_pkg::LOCK_RESET; // [RULE_05]
      quad_io_enable_q <= 1'b0;
      protect_mode_hi_q <= 1'b0;
      sr_write_refused_q <= 1'b0;
    end else begin
      protect_invert_q <= protect_invert_d;
      otp_lock_bits_q <= otp_lock_bits_d;
      quad_io_enable_q <= quad_io_enable_d;
      protect_mode_hi_q <= protect_mode_hi_d;
      sr_write_refused_q <= sr_write_refused_d;
    end
  end

  // =======================================================
  // read view; read-only fields are never taken from write data
  always_comb begin
    status_two_q = status_two_pkg::STATUS_TWO_RESET;
    status_two_q[status_two_pkg::SUSPEND_BIT] = suspend_flag_q;
    status_two_q[status_two_pkg::INVERT_BIT] = protect_invert_q;
    status_two_q[status_two_pkg::LOCK_HI_BIT:status_two_pkg::LOCK_LO_BIT] =
      otp_lock_bits_q; // [RULE_20] [RULE_06]
    status_two_q[status_two_pkg::RESERVED_BIT] = 1'b0; // [RULE_19]
    status_two_q[status_two_pkg::QUAD_BIT] = quad_io_enable_q;
    status_two_q[status_two_pkg::MODE_HI_BIT] = protect_mode_hi_q;
  end

  // =======================================================
  // security register permission; register 0 is factory content
  assign otp_locked = {otp_lock_bits_q, 1'b1}; // [RULE_09]
  assign otp_prog_ok = otp_prog_valid & ~otp_locked[otp_prog_reg]; // [RULE_08]

  // array protection, reversed by the invert bit
  assign array_write_ok = protect_invert_q ? region_bp_hit
                                           : ~region_bp_hit; // [RULE_04]

  // =======================================================
  // pin roles
  assign quad_io_enable = quad_io_enable_q;
  assign wp_function_active = ~quad_io_enable_q; // [RULE_11]
  assign hold_function_active = ~quad_io_enable_q &
    ~hold_reset_select; // [RULE_18]

  // data lines driven only in quad mode, registered for clean timing
  logic [1:0] io_out_q;
  logic [1:0] io_out_d;
  logic io_oe_q;
  logic io_oe_d;
  logic [1:0] io_sample_d;

  always_comb begin
    io_out_d = io_drive_data;
    io_oe_d = quad_io_enable_q & io_drive_req; // [RULE_12]
    io_sample_d = quad_io_enable_q ? {hold_n_s, wp_n_s} : 2'h0;
  end

  // pin drive registers, so the pads see no decode glitches
  always_ff @(posedge clk) begin
    if (reset) begin
      io_out_q <= 2'h0;
      io_oe_q <= 1'b0;
      io_sample_q <= 2'h0;
    end else begin
      io_out_q <= io_out_d;
      io_oe_q <= io_oe_d;
      io_sample_q <= io_sample_d;
    end
  end

  assign data_line_two_o = io_out_q[0];
  assign data_line_three_o = io_out_q[1];
  assign data_line_two_oe = io_oe_q;
  assign data_line_three_oe = io_oe_q;

endmodule

// ===== rtl/pin_sync.sv
// three-stage pin synchroniser that accepts a change once settled
`timescale 1ns/100ps
module pin_sync (
  input wire logic clk,
  input wire logic reset,
  pin_sync_if.sync pins
);

  // =======================================================
  // stages
  logic [2:0] meta_q;
  logic [2:0] meta_d;
  logic [2:0] mid_q;
  logic [2:0] mid_d;
  logic [2:0] last_q;
  logic [2:0] last_d;
  logic [2:0] clean_q;
  logic [2:0] clean_d;

  // first stage is read only by the second; pins idle high
  always_comb begin
    meta_d = pins.raw;
    mid_d = meta_q;
    last_d = mid_q;
    clean_d = clean_q;
    for (int i = 0; i < 3; i++) begin
      if (mid_q[i] == last_q[i]) begin
        clean_d[i] = last_q[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= 3'h7;
      mid_q <= 3'h7;
      last_q <= 3'h7;
      clean_q <= 3'h7;
    end else begin
      meta_q <= meta_d;
      mid_q <= mid_d;
      last_q <= last_d;
      clean_q <= clean_d;
    end
  end

  assign pins.clean = clean_q;

endmodule

// ===== rtl/pin_sync_if.sv
// carrier between the flash pins and their synchroniser
`timescale 1ns/100ps
interface pin_sync_if;
  logic [2:0] raw;
  logic [2:0] clean;
  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// ===== rtl/status_two_pkg.sv
// constants for the second status register of the serial flash
// Contract
// RULE_01: suspend command sets read-only bit 7
// RULE_02: resume or any reset clears suspend flag
// RULE_03: bit 6 inverts protection map, resets zero
// RULE_04: inverted map swaps writable and protected regions
// RULE_05: lock field bits 5:3, read-only, reset zero
// RULE_06: bit 5 reg 3, bit 4 reg 2, bit 3 reg 1
// RULE_07: programming byte 128 sets its lock bit; the code locks on byte 127 (SEC_LAST_BYTE, 7'h7f)
// RULE_08: locked security register refuses further programming
// RULE_09: security register 0 always locked, no bit
// RULE_10: bit 1 quad enable, read/write, reset zero
// RULE_11: quad off keeps pins in control roles
// RULE_12: quad on turns pins into data lines
// RULE_13: quad enable gates quad and xip reads
// RULE_14: quad enable gates program, wrap, id read
// RULE_15: bit 0 upper protect-mode bit, reset zero
// RULE_16: modes zero-one with pin low block writes
// RULE_17: both modes and lock set block permanently
// RULE_18: hold/reset selection only while quad off
// RULE_19: bit 2 reads zero, ignores writes
// RULE_20: status writes keep read-only fields unchanged
package status_two_pkg;

  // =======================================================
  // register layout
  localparam int unsigned SUSPEND_BIT = 7;
  localparam int unsigned INVERT_BIT = 6;
  localparam int unsigned LOCK_HI_BIT = 5;
  localparam int unsigned LOCK_LO_BIT = 3;
  localparam int unsigned RESERVED_BIT = 2;
  localparam int unsigned QUAD_BIT = 1;
  localparam int unsigned MODE_HI_BIT = 0;
  localparam logic [7:0] STATUS_TWO_RESET = 8'h00;
  localparam logic [7:0] WRITABLE_MASK = 8'h43;
  localparam logic [2:0] LOCK_RESET = 3'h0;

  // =======================================================
  // command opcodes
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_WRITE_STATUS_TWO = 8'h31;
  localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6b;
  localparam logic [7:0] OP_XIP_READ = 8'heb;
  localparam logic [7:0] OP_XIP_READ_DW = 8'he7;
  localparam logic [7:0] OP_QUAD_PAGE_PROG = 8'h32;
  localparam logic [7:0] OP_BURST_WRAP = 8'h77;
  localparam logic [7:0] OP_QUAD_ID_READ = 8'h94;

  // =======================================================
  // security registers
  localparam int unsigned SEC_REG_COUNT = 4;
  localparam logic [6:0] SEC_LAST_BYTE = 7'h7f;

  // =======================================================
  // software reset sequencer
  typedef enum logic [0:0] {
    SWR_IDLE = 1'b0,
    SWR_ARMED = 1'b1
  } swr_state_t;

endpackage
